// File: verilog/hyp_status_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "hyp_defines.svh"
// How it works
// - Track virtualization mode; two-stage translation follows it.
// - Hypervisor width 32 hides guest width field.
// - Guest width field keeps only legal encodings.
// - Width grows from 32: guest field widest.
// - Supervisor return traps in guest when enabled.
// - Guest wait traps when enabled, machine trap clear.
// - Guest translation instructions trap when enabled.
// - Guest interrupt selector holds zero to count.
// - User mode vm accesses gated by allow bit.
// - Hypervisor trap saves virtualization mode.
// - Return with mode clear restores saved mode.
// - Guest trap saves nominal privilege, else keep.
// - Saved virtual privilege drives vm access privilege.
// - Guest endianness bit, writable, drives guest accesses.
// - Exception and interrupt delegation registers present.
// - Delegated exception goes to guest when virtual.
// - Fixed writable and zero exception delegation bits.
// - Misaligned-fetch delegation bit writable, alignment 32.
// - Upper exception delegation alias only at 32.
// - Delegated interrupt goes to guest when bit set.
// - Guest interrupt codes translated to supervisor codes.
module hyp_status_unit (
  input  wire logic                CORE_CLK_IN,
  input  wire logic                RESET_IN,
  input  wire logic [3:0]          REG_ADDR_IN,
  input  wire logic [63:0]         REG_WDATA_IN,
  input  wire logic                REG_WRITE_IN,
  input  wire logic                REG_READ_IN,
  output logic      [63:0]         REG_RDATA_OUT,
  input  wire logic                HYP_WIDTH_32_IN,
  input  wire logic                TRAP_VALID_IN,
  input  wire hyp_pkg::trap_req_t  TRAP_REQ_IN,
  output logic                     TRAP_TO_GUEST_OUT,
  output logic                     TRAP_TO_HYP_OUT,
  output logic      [5:0]          TRAP_CAUSE_OUT,
  input  wire logic                SUP_RETURN_IN,
  input  wire logic                MACHINE_RETURN_IN,
  input  wire logic                MACHINE_RETURN_VIRT_IN,
  input  wire logic                INSN_VALID_IN,
  input  wire hyp_pkg::insn_kind_t INSN_KIND_IN,
  input  wire logic [1:0]          CUR_PRIV_IN,
  input  wire logic                MACHINE_WAIT_TRAP_IN,
  output logic                     VIRT_INSN_FAULT_OUT,
  output logic                     ILLEGAL_INSN_OUT,
  output logic                     VIRT_MODE_OUT,
  output logic                     TWO_STAGE_ON_OUT,
  output logic                     GUEST_WIDTH_64_OUT,
  output logic      [5:0]          GUEST_INT_SELECT_OUT,
  output logic                     GUEST_BIG_ENDIAN_OUT,
  output logic                     VM_ACCESS_PRIV_S_OUT
);

  // State
  logic        virt_mode_ff;
  logic        width_32_seen_ff;
  logic [1:0]  guest_width_field_ff;
  logic        trap_sup_return_ff;
  logic        trap_wait_ff;
  logic        trap_virt_mem_ff;
  logic [5:0]  guest_int_select_ff;
  logic        user_hyp_allow_ff;
  logic        prev_virt_ff;
  logic        prev_virt_priv_ff;
  logic        guest_addr_flag_ff;
  logic        guest_big_endian_ff;
  logic [63:0] exc_deleg_ff;
  logic [63:0] int_deleg_ff;
  logic [63:0] rdata_ff;

  // Next values
  wire         nxt_virt_mode;
  wire  [1:0]  nxt_guest_width_field;
  wire         nxt_trap_sup_return;
  wire         nxt_trap_wait;
  wire         nxt_trap_virt_mem;
  wire  [5:0]  nxt_guest_int_select;
  wire         nxt_user_hyp_allow;
  wire         nxt_prev_virt;
  wire         nxt_prev_virt_priv;
  wire         nxt_guest_addr_flag;
  wire         nxt_guest_big_endian;
  wire  [63:0] nxt_exc_deleg;
  wire  [63:0] nxt_int_deleg;
  wire  [63:0] nxt_rdata;

  // Decode
  wire         wr_status;
  wire         wr_exc;
  wire         wr_exc_upper;
  wire         wr_int;
  wire         width_grew;
  wire  [1:0]  wr_width_enc;
  wire         wr_width_legal;
  wire  [5:0]  wr_int_sel;
  wire         wr_int_sel_legal;
  wire  [63:0] exc_wr_en;
  wire  [63:0] exc_wr_data;
  wire  [63:0] int_wr_en;
  wire  [63:0] word_mask;
  wire  [63:0] status_view;
  wire  [63:0] exc_view;
  wire  [63:0] exc_upper_view;
  wire  [63:0] int_view;
  wire  [63:0] rd_sel;

  // Trap and instruction decisions
  hyp_pkg::trap_route_t route;
  hyp_pkg::insn_fault_t fault;
  wire         trap_to_hyp;
  wire         trap_to_machine;

  hyp_trap_route u_route (
    .virt_mode_in  (virt_mode_ff),
    .trap_valid_in (TRAP_VALID_IN),
    .trap_in       (TRAP_REQ_IN),
    .exc_deleg_in  (exc_deleg_ff),
    .int_deleg_in  (int_deleg_ff),
    .route_out     (route)
  );

  hyp_insn_check u_check (
    .insn_valid_in        (INSN_VALID_IN),
    .insn_kind_in         (INSN_KIND_IN),
    .virt_mode_in         (virt_mode_ff),
    .cur_priv_in          (CUR_PRIV_IN),
    .trap_sup_return_in   (trap_sup_return_ff),
    .trap_wait_in         (trap_wait_ff),
    .trap_virt_mem_in     (trap_virt_mem_ff),
    .machine_wait_trap_in (MACHINE_WAIT_TRAP_IN),
    .user_hyp_allow_in    (user_hyp_allow_ff),
    .fault_out            (fault)
  );

  assign trap_to_hyp     = route.to_hyp;
  assign trap_to_machine = TRAP_VALID_IN & ~route.to_guest & ~route.to_hyp;

  // Register strobes
  assign wr_status    = REG_WRITE_IN & (REG_ADDR_IN == `REG_HYP_STATUS);
  assign wr_exc       = REG_WRITE_IN & (REG_ADDR_IN == `REG_EXC_DELEGATE);
  assign wr_exc_upper = REG_WRITE_IN & (REG_ADDR_IN == `REG_EXC_DELEGATE_UPPER)
                      & HYP_WIDTH_32_IN;
  assign wr_int       = REG_WRITE_IN & (REG_ADDR_IN == `REG_INT_DELEGATE);
  assign word_mask    = HYP_WIDTH_32_IN ? `LOW_WORD_MASK : ~`DELEG_RESET;

  // Virtualization mode
  assign nxt_virt_mode = (trap_to_hyp | trap_to_machine) ? 1'b0 :
                         (SUP_RETURN_IN & ~virt_mode_ff) ? prev_virt_ff :
                         MACHINE_RETURN_IN ? MACHINE_RETURN_VIRT_IN :
                         virt_mode_ff;

  // Guest width field
  assign width_grew     = width_32_seen_ff & ~HYP_WIDTH_32_IN;
  assign wr_width_enc   = REG_WDATA_IN[`ST_GUEST_WIDTH_HI:`ST_GUEST_WIDTH_LO];
  assign wr_width_legal = (wr_width_enc == `WIDTH_ENC_32) |
                          (wr_width_enc == `WIDTH_ENC_64);
  assign nxt_guest_width_field =
    width_grew ? `WIDTH_ENC_64 :
    (wr_status & ~HYP_WIDTH_32_IN & wr_width_legal) ? wr_width_enc :
    guest_width_field_ff;

  // Guest interrupt selector, out-of-range writes keep the old value
  assign wr_int_sel       = REG_WDATA_IN[`ST_GUEST_INT_SEL_HI:`ST_GUEST_INT_SEL_LO];
  assign wr_int_sel_legal = (wr_int_sel <= `GUEST_INT_COUNT);
  assign nxt_guest_int_select = (wr_status & wr_int_sel_legal) ? wr_int_sel
                                                               : guest_int_select_ff;

  // Software-only control bits
  assign nxt_trap_sup_return  = wr_status ? REG_WDATA_IN[`ST_TRAP_SUP_RETURN]
                                          : trap_sup_return_ff;
  assign nxt_trap_wait        = wr_status ? REG_WDATA_IN[`ST_TRAP_WAIT]
                                          : trap_wait_ff;
  assign nxt_trap_virt_mem    = wr_status ? REG_WDATA_IN[`ST_TRAP_VIRT_MEM]
                                          : trap_virt_mem_ff;
  assign nxt_user_hyp_allow   = wr_status ? REG_WDATA_IN[`ST_USER_HYP_ALLOW]
                                          : user_hyp_allow_ff;
  assign nxt_guest_big_endian = wr_status ? REG_WDATA_IN[`ST_GUEST_BIG_ENDIAN]
                                          : guest_big_endian_ff;

  // Trap-written bits; a hypervisor trap in the same cycle wins over a software write
  assign nxt_prev_virt = trap_to_hyp ? virt_mode_ff :
                         wr_status ? REG_WDATA_IN[`ST_PREV_VIRT] : prev_virt_ff;
  assign nxt_prev_virt_priv =
    (trap_to_hyp & virt_mode_ff) ? TRAP_REQ_IN.nominal_priv_s :
    trap_to_hyp ? prev_virt_priv_ff :
    wr_status ? REG_WDATA_IN[`ST_PREV_VIRT_PRIV] : prev_virt_priv_ff;
  assign nxt_guest_addr_flag = trap_to_hyp ? TRAP_REQ_IN.guest_addr :
                               wr_status ? REG_WDATA_IN[`ST_GUEST_ADDR_FLAG]
                                         : guest_addr_flag_ff;

  // Delegation write lanes; the upper alias lands in bits 63:32
  assign exc_wr_en   = wr_exc ? word_mask :
                       wr_exc_upper ? `HIGH_WORD_MASK : `DELEG_RESET;
  assign exc_wr_data = wr_exc_upper ? {REG_WDATA_IN[31:0], 32'h0000_0000}
                                    : REG_WDATA_IN;
  assign int_wr_en   = wr_int ? word_mask : `DELEG_RESET;

  localparam logic [63:0] EXC_WRITABLE = `EXC_DELEG_WRITABLE;
  localparam logic [63:0] INT_WRITABLE = `INT_DELEG_WRITABLE;

  genvar b;
  generate
    for (b = 0; b < 64; b = b + 1) begin : g_deleg
      // Read-only-zero bits never hold a one
      assign nxt_exc_deleg[b] = EXC_WRITABLE[b] &
                                (exc_wr_en[b] ? exc_wr_data[b] : exc_deleg_ff[b]);
      assign nxt_int_deleg[b] = INT_WRITABLE[b] &
                                (int_wr_en[b] ? REG_WDATA_IN[b] : int_deleg_ff[b]);
    end
  endgenerate

  // Read views
  assign status_view[`ST_GUEST_BIG_ENDIAN-1:0]   = 5'h00;
  assign status_view[`ST_GUEST_BIG_ENDIAN]       = guest_big_endian_ff;
  assign status_view[`ST_GUEST_ADDR_FLAG]        = guest_addr_flag_ff;
  assign status_view[`ST_PREV_VIRT]              = prev_virt_ff;
  assign status_view[`ST_PREV_VIRT_PRIV]         = prev_virt_priv_ff;
  assign status_view[`ST_USER_HYP_ALLOW]         = user_hyp_allow_ff;
  assign status_view[`ST_GUEST_INT_SEL_LO-1:10]  = 2'h0;
  assign status_view[`ST_GUEST_INT_SEL_HI:`ST_GUEST_INT_SEL_LO] = guest_int_select_ff;
  assign status_view[`ST_TRAP_VIRT_MEM-1:18]     = 2'h0;
  assign status_view[`ST_TRAP_VIRT_MEM]          = trap_virt_mem_ff;
  assign status_view[`ST_TRAP_WAIT]              = trap_wait_ff;
  assign status_view[`ST_TRAP_SUP_RETURN]        = trap_sup_return_ff;
  assign status_view[`ST_GUEST_WIDTH_LO-1:23]    = 9'h000;
  assign status_view[`ST_GUEST_WIDTH_HI:`ST_GUEST_WIDTH_LO] =
    HYP_WIDTH_32_IN ? 2'h0 : guest_width_field_ff;
  assign status_view[63:`ST_GUEST_WIDTH_HI+1]    = 30'h0000_0000;

  assign exc_view       = exc_deleg_ff & word_mask;
  assign exc_upper_view = HYP_WIDTH_32_IN ? {32'h0000_0000, exc_deleg_ff[63:32]}
                                          : `DELEG_RESET;
  assign int_view       = int_deleg_ff & word_mask;

  assign rd_sel = (REG_ADDR_IN == `REG_HYP_STATUS)         ? status_view :
                  (REG_ADDR_IN == `REG_EXC_DELEGATE)       ? exc_view :
                  (REG_ADDR_IN == `REG_EXC_DELEGATE_UPPER) ? exc_upper_view :
                  (REG_ADDR_IN == `REG_INT_DELEGATE)       ? int_view :
                  `DELEG_RESET;
  // Read data stand for one cycle only, zero otherwise
  assign nxt_rdata = REG_READ_IN ? rd_sel : `DELEG_RESET;

  // Registers
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      virt_mode_ff         <= 1'b0;
      width_32_seen_ff     <= 1'b0;
      guest_width_field_ff <= `GUEST_WIDTH_RESET;
      trap_sup_return_ff   <= 1'b0;
      trap_wait_ff         <= 1'b0;
      trap_virt_mem_ff     <= 1'b0;
      guest_int_select_ff  <= `GUEST_INT_SEL_RESET;
      user_hyp_allow_ff    <= 1'b0;
      prev_virt_ff         <= 1'b0;
      prev_virt_priv_ff    <= 1'b0;
      guest_addr_flag_ff   <= 1'b0;
      guest_big_endian_ff  <= 1'b0;
      exc_deleg_ff         <= `DELEG_RESET;
      int_deleg_ff         <= `DELEG_RESET;
      rdata_ff             <= `DELEG_RESET;
    end else begin
      virt_mode_ff         <= nxt_virt_mode;
      width_32_seen_ff     <= HYP_WIDTH_32_IN;
      guest_width_field_ff <= nxt_guest_width_field;
      trap_sup_return_ff   <= nxt_trap_sup_return;
      trap_wait_ff         <= nxt_trap_wait;
      trap_virt_mem_ff     <= nxt_trap_virt_mem;
      guest_int_select_ff  <= nxt_guest_int_select;
      user_hyp_allow_ff    <= nxt_user_hyp_allow;
      prev_virt_ff         <= nxt_prev_virt;
      prev_virt_priv_ff    <= nxt_prev_virt_priv;
      guest_addr_flag_ff   <= nxt_guest_addr_flag;
      guest_big_endian_ff  <= nxt_guest_big_endian;
      exc_deleg_ff         <= nxt_exc_deleg;
      int_deleg_ff         <= nxt_int_deleg;
      rdata_ff             <= nxt_rdata;
    end
  end

  // Outputs
  assign REG_RDATA_OUT        = rdata_ff;
  assign TRAP_TO_GUEST_OUT    = route.to_guest;
  assign TRAP_TO_HYP_OUT      = route.to_hyp;
  assign TRAP_CAUSE_OUT       = route.cause;
  assign VIRT_INSN_FAULT_OUT  = fault.virt_insn;
  assign ILLEGAL_INSN_OUT     = fault.illegal_insn;
  assign VIRT_MODE_OUT        = virt_mode_ff;
  assign TWO_STAGE_ON_OUT     = virt_mode_ff;
  assign GUEST_WIDTH_64_OUT   = ~HYP_WIDTH_32_IN &
                                (guest_width_field_ff == `WIDTH_ENC_64);
  assign GUEST_INT_SELECT_OUT = guest_int_select_ff;
  assign GUEST_BIG_ENDIAN_OUT = guest_big_endian_ff;
  assign VM_ACCESS_PRIV_S_OUT = prev_virt_priv_ff;

endmodule : hyp_status_unit
`default_nettype wire

// File: verilog/hyp_defines.svh
`ifndef HYP_DEFINES_SVH
`define HYP_DEFINES_SVH
`define REG_HYP_STATUS          4'h0
`define REG_EXC_DELEGATE        4'h1
`define REG_EXC_DELEGATE_UPPER  4'h2
`define REG_INT_DELEGATE        4'h3
`define ST_GUEST_BIG_ENDIAN     5
`define ST_GUEST_ADDR_FLAG      6
`define ST_PREV_VIRT            7
`define ST_PREV_VIRT_PRIV       8
`define ST_USER_HYP_ALLOW       9
`define ST_GUEST_INT_SEL_LO     12
`define ST_GUEST_INT_SEL_HI     17
`define ST_TRAP_VIRT_MEM        20
`define ST_TRAP_WAIT            21
`define ST_TRAP_SUP_RETURN      22
`define ST_GUEST_WIDTH_LO       32
`define ST_GUEST_WIDTH_HI       33
`define WIDTH_ENC_32            2'h1
`define WIDTH_ENC_64            2'h2
`define GUEST_WIDTH_RESET       2'h2
`define GUEST_INT_COUNT         6'h07
`define GUEST_INT_SEL_RESET     6'h00
`define EXC_DELEG_WRITABLE      64'h0000_0000_000C_B1FF
`define INT_DELEG_WRITABLE      64'h0000_0000_0000_0444
`define DELEG_RESET             64'h0000_0000_0000_0000
`define LOW_WORD_MASK           64'h0000_0000_FFFF_FFFF
`define HIGH_WORD_MASK          64'hFFFF_FFFF_0000_0000
`define PRIV_USER               2'h0
`define PRIV_SUPER              2'h1
`define CODE_GUEST_EXT          6'h0A
`define CODE_GUEST_TIMER        6'h06
`define CODE_GUEST_SOFT         6'h02
`endif

// File: verilog/hyp_pkg.sv
package hyp_pkg;

  typedef enum logic [3:0] {
    INSN_OTHER                  = 4'h0,
    INSN_SUPERVISOR_RETURN      = 4'h1,
    INSN_WAIT_FOR_INTERRUPT     = 4'h2,
    INSN_TRANSLATION_FENCE      = 4'h3,
    INSN_TRANSLATION_INVALIDATE = 4'h4,
    INSN_TRANSLATION_REG_ACCESS = 4'h5,
    INSN_VM_LOAD                = 4'h6,
    INSN_VM_LOAD_EXECUTE        = 4'h7,
    INSN_VM_STORE               = 4'h8,
    INSN_HYP_OTHER              = 4'h9
  } insn_kind_t;

  typedef struct packed {
    logic       is_interrupt;
    logic [5:0] code;
    logic       nominal_priv_s;
    logic       guest_addr;
    logic       machine_deleg;
  } trap_req_t;

  typedef struct packed {
    logic       to_guest;
    logic       to_hyp;
    logic [5:0] cause;
  } trap_route_t;

  typedef struct packed {
    logic virt_insn;
    logic illegal_insn;
  } insn_fault_t;

endpackage : hyp_pkg

// File: verilog/hyp_trap_route.sv
`timescale 1ns/10ps
`default_nettype none
`include "hyp_defines.svh"
module hyp_trap_route (
  input  wire logic              virt_mode_in,
  input  wire logic              trap_valid_in,
  input  wire hyp_pkg::trap_req_t trap_in,
  input  wire logic [63:0]       exc_deleg_in,
  input  wire logic [63:0]       int_deleg_in,
  output hyp_pkg::trap_route_t   route_out
);
  wire       deleg_bit;
  wire       to_guest;
  wire [5:0] guest_code;

  assign deleg_bit = trap_in.is_interrupt ? int_deleg_in[trap_in.code]
                                          : exc_deleg_in[trap_in.code];
  assign to_guest = trap_valid_in & trap_in.machine_deleg & deleg_bit
                  & (trap_in.is_interrupt | virt_mode_in);
  // Guest-level interrupt codes are seen by the guest as supervisor codes
  assign guest_code = (trap_in.is_interrupt &&
                       (trap_in.code == `CODE_GUEST_EXT ||
                        trap_in.code == `CODE_GUEST_TIMER ||
                        trap_in.code == `CODE_GUEST_SOFT))
                      ? trap_in.code - 6'h01 : trap_in.code;

  assign route_out.to_guest = to_guest;
  assign route_out.to_hyp   = trap_valid_in & trap_in.machine_deleg & ~to_guest;
  assign route_out.cause    = to_guest ? guest_code : trap_in.code;
endmodule : hyp_trap_route
`default_nettype wire

// File: verilog/hyp_insn_check.sv
`timescale 1ns/10ps
`default_nettype none
`include "hyp_defines.svh"
module hyp_insn_check (
  input  wire logic                insn_valid_in,
  input  wire hyp_pkg::insn_kind_t insn_kind_in,
  input  wire logic                virt_mode_in,
  input  wire logic [1:0]          cur_priv_in,
  input  wire logic                trap_sup_return_in,
  input  wire logic                trap_wait_in,
  input  wire logic                trap_virt_mem_in,
  input  wire logic                machine_wait_trap_in,
  input  wire logic                user_hyp_allow_in,
  output hyp_pkg::insn_fault_t     fault_out
);
  wire in_guest_super;
  wire in_host_user;
  wire is_vm_access;
  wire is_hyp_insn;
  wire is_translation;
  wire guest_trap;

  assign in_guest_super = virt_mode_in & (cur_priv_in == `PRIV_SUPER);
  assign in_host_user   = ~virt_mode_in & (cur_priv_in == `PRIV_USER);
  assign is_vm_access   = (insn_kind_in == hyp_pkg::INSN_VM_LOAD) |
                          (insn_kind_in == hyp_pkg::INSN_VM_LOAD_EXECUTE) |
                          (insn_kind_in == hyp_pkg::INSN_VM_STORE);
  assign is_hyp_insn    = is_vm_access | (insn_kind_in == hyp_pkg::INSN_HYP_OTHER);
  assign is_translation = (insn_kind_in == hyp_pkg::INSN_TRANSLATION_FENCE) |
                          (insn_kind_in == hyp_pkg::INSN_TRANSLATION_INVALIDATE) |
                          (insn_kind_in == hyp_pkg::INSN_TRANSLATION_REG_ACCESS);
  // Wait in the guest traps at once, without waiting for a time limit
  assign guest_trap =
    ((insn_kind_in == hyp_pkg::INSN_SUPERVISOR_RETURN) & trap_sup_return_in) |
    ((insn_kind_in == hyp_pkg::INSN_WAIT_FOR_INTERRUPT) & trap_wait_in
      & ~machine_wait_trap_in) |
    (is_translation & trap_virt_mem_in);

  assign fault_out.virt_insn    = insn_valid_in & in_guest_super & guest_trap;
  assign fault_out.illegal_insn = insn_valid_in & in_host_user & is_hyp_insn
                                & ~(user_hyp_allow_in & is_vm_access);
endmodule : hyp_insn_check
`default_nettype wire

// File: bench/hyp_status_unit_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module hyp_status_unit_monitor (
  input wire logic                CORE_CLK_IN,
  input wire logic                RESET_IN,
  input wire logic                HYP_WIDTH_32_IN,
  input wire logic                TRAP_VALID_IN,
  input wire hyp_pkg::trap_req_t  TRAP_REQ_IN,
  input wire logic                TRAP_TO_GUEST_OUT,
  input wire logic                TRAP_TO_HYP_OUT,
  input wire logic [5:0]          TRAP_CAUSE_OUT,
  input wire logic                INSN_VALID_IN,
  input wire hyp_pkg::insn_kind_t INSN_KIND_IN,
  input wire logic [1:0]          CUR_PRIV_IN,
  input wire logic                VIRT_INSN_FAULT_OUT,
  input wire logic                ILLEGAL_INSN_OUT,
  input wire logic                VIRT_MODE_OUT,
  input wire logic                GUEST_WIDTH_64_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  property p_w32; HYP_WIDTH_32_IN |-> !GUEST_WIDTH_64_OUT; endproperty
  a_w32: assert property (p_w32) else $error("guest width wide");
  property p_grow; $fell(HYP_WIDTH_32_IN) |-> ##[1:2] GUEST_WIDTH_64_OUT; endproperty
  a_grow: assert property (p_grow) else $error("guest width not widened");
  property p_vscope; !VIRT_MODE_OUT || CUR_PRIV_IN != 2'h1 |-> !VIRT_INSN_FAULT_OUT; endproperty
  a_vscope: assert property (p_vscope) else $error("virtual fault outside guest");
  property p_hyp_ill; INSN_VALID_IN && !VIRT_MODE_OUT && CUR_PRIV_IN == 2'h0
    && INSN_KIND_IN == hyp_pkg::INSN_HYP_OTHER |-> ILLEGAL_INSN_OUT; endproperty
  a_hyp_ill: assert property (p_hyp_ill) else $error("user hyp insn allowed");
  property p_hyp_v; TRAP_VALID_IN && !TRAP_TO_GUEST_OUT |=> !VIRT_MODE_OUT; endproperty
  a_hyp_v: assert property (p_hyp_v) else $error("mode kept on host trap");
  property p_g_v; TRAP_VALID_IN && TRAP_TO_GUEST_OUT |=> $stable(VIRT_MODE_OUT); endproperty
  a_g_v: assert property (p_g_v) else $error("mode changed on guest trap");
  property p_cause; TRAP_VALID_IN && TRAP_TO_GUEST_OUT && TRAP_REQ_IN.is_interrupt
    && TRAP_REQ_IN.code inside {6'h02, 6'h06, 6'h0A}
    |-> TRAP_CAUSE_OUT == TRAP_REQ_IN.code - 6'h01; endproperty
  a_cause: assert property (p_cause) else $error("cause not translated");
  property p_gate; TRAP_VALID_IN && !TRAP_REQ_IN.machine_deleg
    |-> !TRAP_TO_GUEST_OUT && !TRAP_TO_HYP_OUT; endproperty
  a_gate: assert property (p_gate) else $error("undelegated trap routed");
endmodule : hyp_status_unit_monitor
bind hyp_status_unit hyp_status_unit_monitor hyp_status_unit_monitor_i (
  .CORE_CLK_IN(CORE_CLK_IN), .RESET_IN(RESET_IN), .HYP_WIDTH_32_IN(HYP_WIDTH_32_IN),
  .TRAP_VALID_IN(TRAP_VALID_IN), .TRAP_REQ_IN(TRAP_REQ_IN),
  .TRAP_TO_GUEST_OUT(TRAP_TO_GUEST_OUT), .TRAP_TO_HYP_OUT(TRAP_TO_HYP_OUT),
  .TRAP_CAUSE_OUT(TRAP_CAUSE_OUT), .INSN_VALID_IN(INSN_VALID_IN), .INSN_KIND_IN(INSN_KIND_IN),
  .CUR_PRIV_IN(CUR_PRIV_IN), .VIRT_INSN_FAULT_OUT(VIRT_INSN_FAULT_OUT),
  .ILLEGAL_INSN_OUT(ILLEGAL_INSN_OUT), .VIRT_MODE_OUT(VIRT_MODE_OUT),
  .GUEST_WIDTH_64_OUT(GUEST_WIDTH_64_OUT));
`default_nettype wire

// File: bench/hart_model.sv
`timescale 1ns/10ps
`default_nettype none
module hart_model (
  output logic                tv_out,
  output hyp_pkg::trap_req_t  treq_out,
  output logic                sr_out,
  output logic                mret_out,
  output logic                mret_v_out,
  output logic                iv_out,
  output hyp_pkg::insn_kind_t ik_out,
  output logic [1:0]          priv_out,
  output logic                mwt_out
);
  initial begin
    priv_out <= 2'h3;
    mwt_out <= 1'b0;
    idle();
  end
  // Drops pulses; stale request bits are scrambled
  task automatic idle();
    tv_out <= 1'b0;
    treq_out <= ~treq_out;
    sr_out <= 1'b0;
    mret_out <= 1'b0;
    mret_v_out <= ~mret_v_out;
    iv_out <= 1'b0;
    ik_out <= hyp_pkg::INSN_OTHER;
  endtask : idle
  task automatic trap_on(input hyp_pkg::trap_req_t r);
    tv_out <= 1'b1;
    treq_out <= r;
  endtask : trap_on
  task automatic ret_on(input logic s, input logic m, input logic v);
    sr_out <= s;
    mret_out <= m;
    mret_v_out <= v;
  endtask : ret_on
  task automatic insn_on(input hyp_pkg::insn_kind_t k, input logic [1:0] p, input logic w);
    iv_out <= 1'b1;
    ik_out <= k;
    priv_out <= p;
    mwt_out <= w;
  endtask : insn_on
endmodule : hart_model
`default_nettype wire

// File: bench/test_hyp_status_unit.sv
`timescale 1ns/10ps
`default_nettype none
module test_hyp_status_unit;
  localparam logic [63:0] EXC_W = 64'h1FF | 64'h1 << 12 | 64'h1 << 13 | 64'h1 << 15
    | 64'h1 << 18 | 64'h1 << 19;
  localparam logic [63:0] INT_W = 64'h1 << 10 | 64'h1 << 6 | 64'h1 << 2;
  logic core_clk, rst, wr_s, rd_s, w32, tv, sr, mret, mret_v, iv, mwt;
  logic to_g, to_h, vflt, ill, vm, two, g64, be, vpriv;
  logic [3:0] addr;
  logic [63:0] wdata, rdata, st, rnd;
  logic [5:0] cause, gsel;
  logic [1:0] priv;
  logic [31:0] seed;
  hyp_pkg::trap_req_t treq;
  hyp_pkg::insn_kind_t ik;
  int fails, num_checks;
  hyp_status_unit hyp_status_unit_i (
    .CORE_CLK_IN(core_clk), .RESET_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WRITE_IN(wr_s), .REG_READ_IN(rd_s), .REG_RDATA_OUT(rdata), .HYP_WIDTH_32_IN(w32),
    .TRAP_VALID_IN(tv), .TRAP_REQ_IN(treq), .TRAP_TO_GUEST_OUT(to_g), .TRAP_TO_HYP_OUT(to_h),
    .TRAP_CAUSE_OUT(cause), .SUP_RETURN_IN(sr), .MACHINE_RETURN_IN(mret),
    .MACHINE_RETURN_VIRT_IN(mret_v), .INSN_VALID_IN(iv), .INSN_KIND_IN(ik), .CUR_PRIV_IN(priv),
    .MACHINE_WAIT_TRAP_IN(mwt), .VIRT_INSN_FAULT_OUT(vflt), .ILLEGAL_INSN_OUT(ill),
    .VIRT_MODE_OUT(vm), .TWO_STAGE_ON_OUT(two), .GUEST_WIDTH_64_OUT(g64),
    .GUEST_INT_SELECT_OUT(gsel), .GUEST_BIG_ENDIAN_OUT(be), .VM_ACCESS_PRIV_S_OUT(vpriv));
  hart_model hart_model_i (.tv_out(tv), .treq_out(treq), .sr_out(sr), .mret_out(mret),
    .mret_v_out(mret_v), .iv_out(iv), .ik_out(ik), .priv_out(priv), .mwt_out(mwt));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Status after a write at full width
  function automatic logic [63:0] st_exp(input logic [63:0] o, input logic [63:0] d);
    logic [63:0] n;
    n = (o & ~64'h0070_03E0) | (d & 64'h0070_03E0);
    if (d[17:12] <= 6'h07) n[17:12] = d[17:12];
    if (d[33:32] == 2'h1 || d[33:32] == 2'h2) n[33:32] = d[33:32];
    return n;
  endfunction : st_exp
  task automatic conclude();
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge core_clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [63:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge core_clk);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic trp(input hyp_pkg::trap_req_t r, input logic [7:0] e);
    @(posedge core_clk);
    hart_model_i.trap_on(r);
    #1 chk(64'({to_g, to_h, cause}), 64'(e));
    @(posedge core_clk);
    hart_model_i.idle();
  endtask : trp
  task automatic ret(input logic s, input logic m, input logic v, input logic e);
    @(posedge core_clk);
    hart_model_i.ret_on(s, m, v);
    @(posedge core_clk);
    hart_model_i.idle();
    #1 chk(64'({vm, two}), 64'({e, e}));
  endtask : ret
  task automatic ins(input hyp_pkg::insn_kind_t k, input logic [1:0] p, input logic w,
                     input logic [1:0] e);
    @(posedge core_clk);
    hart_model_i.insn_on(k, p, w);
    #1 chk(64'({vflt, ill}), 64'(e));
  endtask : ins
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    rst <= 1'b1;
    addr <= 4'h0;
    wdata <= 64'h0;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    w32 <= 1'b0;
    fails = 0;
    num_checks = 0;
    seed = 32'h0001_6462;
    st = 64'h0000_0002_0000_0000;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0, st);
    rd(4'h1, 64'h0);
    rd(4'h3, 64'h0);
    wr(4'h1, '1);
    rd(4'h1, EXC_W);
    wr(4'h3, '1);
    rd(4'h3, INT_W);
    rd(4'h2, 64'h0);
    repeat (24) begin
      seed = lfsr(seed);
      rnd = {seed, lfsr(seed)};
      wr(4'h0, rnd);
      st = st_exp(st, rnd);
      rd(4'h0, st);
      chk(64'({be, vpriv, gsel, g64}), 64'({st[5], st[8], st[17:12], st[33:32] == 2'h2}));
    end
    st = 64'h0000_0002_0070_0000;
    wr(4'h0, st);
    ret(1'b0, 1'b1, 1'b1, 1'b1);
    trp({1'b0, 6'h02, 3'b101}, {2'h2, 6'h02});
    for (int k = 1; k <= 5; k++) ins(hyp_pkg::insn_kind_t'(k), 2'h1, 1'b0, 2'h2);
    ins(hyp_pkg::INSN_WAIT_FOR_INTERRUPT, 2'h1, 1'b1, 2'h0);
    ins(hyp_pkg::INSN_VM_LOAD_EXECUTE, 2'h1, 1'b0, 2'h0);
    trp({1'b0, 6'h09, 3'b111}, {2'h1, 6'h09});
    st[8:6] = 3'h7;
    rd(4'h0, st);
    chk(64'({vm, vpriv}), 64'h1);
    trp({1'b0, 6'h09, 3'b001}, {2'h1, 6'h09});
    st[7:6] = 2'h0;
    rd(4'h0, st);
    trp({1'b0, 6'h02, 3'b100}, 8'h02);
    ret(1'b1, 1'b0, 1'b0, 1'b0);
    st[7] = 1'b1;
    wr(4'h0, st);
    ret(1'b1, 1'b0, 1'b0, 1'b1);
    for (int c = 2; c <= 10; c += 4) trp({1'b1, 6'(c), 3'b001}, {2'h2, 6'(c - 1)});
    trp({1'b1, 6'h09, 3'b001}, {2'h1, 6'h09});
    st[8:6] = 3'h2;
    rd(4'h0, st);
    ins(hyp_pkg::INSN_VM_LOAD, 2'h0, 1'b0, 2'h1);
    st[9] = 1'b1;
    wr(4'h0, st);
    ins(hyp_pkg::INSN_VM_STORE, 2'h0, 1'b0, 2'h0);
    ins(hyp_pkg::INSN_HYP_OTHER, 2'h0, 1'b0, 2'h1);
    st[33:32] = 2'h1;
    wr(4'h0, st);
    w32 <= 1'b1;
    rd(4'h0, st & 64'h0000_0000_FFFF_FFFF);
    wr(4'h2, '1);
    rd(4'h2, 64'h0);
    w32 <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(64'(g64), 64'h1);
    rd(4'h5, 64'h0);
    conclude();
  end
endmodule : test_hyp_status_unit
`default_nettype wire
